// ### pnp_pkg.sv
/*
 card isolation constants: port addresses, command indexes, isolation
 patterns, memory layout and reset values. assumes isa i/o decode upstream.
*/
package pnp_pkg;

	// isa port addresses
	localparam logic [15:0] ADDR_PORT          = 16'h0279;
	localparam logic [15:0] WDATA_PORT         = 16'h0a79;
	localparam logic [7:0]  RD_PORT_RESET      = 8'h80;

	// command indexes
	localparam logic [7:0]  IDX_SET_RD         = 8'h00;
	localparam logic [7:0]  IDX_ISOLATE        = 8'h01;
	localparam logic [7:0]  IDX_CFG_CTRL       = 8'h02;
	localparam logic [7:0]  IDX_WAKE           = 8'h03;
	localparam logic [7:0]  IDX_RES_DATA       = 8'h04;
	localparam logic [7:0]  IDX_STATUS         = 8'h05;
	localparam logic [7:0]  IDX_CSN            = 8'h06;
	localparam logic [7:0]  IDX_VENDOR_RST_CSN = 8'hf4;
	localparam int          CTRL_WAIT_KEY_BIT  = 1;
	localparam int          CTRL_RST_CSN_BIT   = 2;

	// isolation patterns
	localparam logic [7:0]  ISOL_FIRST         = 8'h55;
	localparam logic [7:0]  ISOL_SECOND        = 8'haa;
	localparam logic [1:0]  SENSE_FIRST        = 2'h1;
	localparam logic [1:0]  SENSE_SECOND       = 2'h2;
	localparam logic [6:0]  ID_BITS            = 7'h48;

	// memory layout
	localparam int          MEM_BYTES          = 64;
	localparam logic [5:0]  LEN_ADDR           = 6'h00;
	localparam logic [5:0]  ID_ADDR            = 6'h01;
	localparam logic [5:0]  RES_START          = 6'h01;
	localparam logic [7:0]  STATUS_READY       = 8'h01;
	localparam logic [7:0]  CSN_RESET          = 8'h00;
	localparam int          FIFO_DEPTH         = 8;

	// initiation key
	localparam logic [7:0]  KEY_SEED           = 8'h6a;
	localparam logic [5:0]  KEY_LEN            = 6'h20;

	typedef enum logic [1:0] {ST_WAIT_KEY, ST_SLEEP, ST_ISOLATE, ST_CONFIG} card_state_t;

endpackage

// ### key_detect.sv
/*
 initiation key detector: matches a run of writes against an lfsr sequence.
 assumes one wr_i pulse per address-port write.
*/
`timescale 1ns/10ps
module key_detect #(
	parameter logic [7:0] SEED = pnp_pkg::KEY_SEED,
	parameter logic [5:0] LEN  = pnp_pkg::KEY_LEN
) (
	// clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       reset_n_i,
	// write stream
	input  wire logic       enable_i,
	input  wire logic       wr_i,
	input  wire logic [7:0] data_i,
	// result
	output logic            found_o
);
	import pnp_pkg::*;

	logic [7:0] expect_q;
	logic [5:0] count_q;

	function automatic logic [7:0] lfsr_next(input logic [7:0] v);
		lfsr_next = {v[0] ^ v[1], v[7:1]};
	endfunction

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i || !enable_i) begin
			expect_q <= SEED;
			count_q  <= 6'h00;
			found_o  <= 1'b0;
		end else begin
			found_o <= 1'b0;
			if (wr_i) begin
				if (data_i == expect_q) begin
					if (count_q == LEN - 6'h01) begin
						found_o  <= 1'b1;
						expect_q <= SEED;
						count_q  <= 6'h00;
					end else begin
						expect_q <= lfsr_next(expect_q);
						count_q  <= count_q + 6'h01;
					end
				end else if (data_i == SEED) begin
					expect_q <= lfsr_next(SEED);
					count_q  <= 6'h01;
				end else begin
					expect_q <= SEED;
					count_q  <= 6'h00;
				end
			end
		end
	end

endmodule

// ### sync_fifo.sv
/*
 synchronous fifo with valid/ready on both sides.
 assumes a single clock; ready on the fill side comes from a flop.
*/
`timescale 1ns/10ps
module sync_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             sys_clk_i,
	input  wire logic             reset_n_i,
	// fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_ptr_q;
	logic [AW-1:0]    rd_ptr_q;
	logic [AW:0]      count_q;
	logic [AW:0]      count_d;
	logic             push;
	logic             pop;

	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	assign out_valid_o = (count_q != '0);
	assign out_data_o  = mem_q[rd_ptr_q];

	always_comb begin
		count_d = count_q;
		if (push && !pop) begin
			count_d = count_q + 1'b1;
		end else if (pop && !push) begin
			count_d = count_q - 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			wr_ptr_q   <= '0;
			rd_ptr_q   <= '0;
			count_q    <= '0;
			in_ready_o <= 1'b1;
		end else begin
			count_q    <= count_d;
			in_ready_o <= (count_d != (AW+1)'(DEPTH));
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data_i;
		end
	end

endmodule

// ### pnp_card_isolation.sv
/*
 plug and play card isolation: key detect, card state machine, serial
 isolation on the read port, card select number, 64-byte data store.
 assumes isa strobes already synchronous; io_rd_i held for the whole read.
*/
`timescale 1ns/10ps
module pnp_card_isolation #(
	parameter int MEM_DEPTH = pnp_pkg::MEM_BYTES,
	parameter int LOAD_DEPTH = pnp_pkg::FIFO_DEPTH
) (
	// clock and reset
	input  wire logic                sys_clk_i,
	input  wire logic                reset_n_i,
	// isa i/o
	input  wire logic [15:0]         io_addr_i,
	input  wire logic                io_wr_i,
	input  wire logic [7:0]          io_wdata_i,
	input  wire logic                io_rd_i,
	input  wire logic [7:0]          sd_i,
	output logic [7:0]               sd_o,
	output logic                     sd_oe_o,
	// microcontroller load port
	input  wire logic                mcu_start_i,
	input  wire logic                mcu_valid_i,
	input  wire logic [7:0]          mcu_data_i,
	output logic                     mcu_ready_o,
	// card status
	output pnp_pkg::card_state_t     card_state_o,
	output logic [7:0]               csn_o
);
	import pnp_pkg::*;

	logic [7:0]  mem_q [MEM_DEPTH];
	card_state_t state_q;
	logic [7:0]  csn_q;
	logic [7:0]  idx_q;
	logic [7:0]  rd_port_q;
	logic [6:0]  bit_cnt_q;
	logic        phase_q;
	logic        drove_q;
	logic        saw_first_q;
	logic [1:0]  sense_q;
	logic        rd_hit_q;
	logic [5:0]  res_ptr_q;
	logic [5:0]  load_ptr_q;
	logic        key_found;
	logic        addr_wr;
	logic        data_wr;
	logic        rd_hit;
	logic        rd_end;
	logic        isol_ctx;
	logic        res_ctx;
	logic        done;
	logic [7:0]  id_byte;
	logic        cur_bit;
	logic        lose;
	logic        resp_oe;
	logic [7:0]  resp_data;
	logic        drain_valid;
	logic        drain_ready;
	logic [7:0]  drain_data;
	logic [5:0]  res_len;

	assign card_state_o = state_q;
	assign csn_o        = csn_q;

	// port decode
	assign addr_wr = io_wr_i && (io_addr_i == ADDR_PORT);
	assign data_wr = io_wr_i && (io_addr_i == WDATA_PORT) && (state_q != ST_WAIT_KEY);
	assign rd_hit  = io_rd_i && (io_addr_i == {6'h00, rd_port_q, 2'h3})
		&& (state_q != ST_WAIT_KEY);
	assign rd_end  = rd_hit_q && !rd_hit;

	// identifier bit lookup
	assign id_byte  = mem_q[ID_ADDR + {2'h0, bit_cnt_q[6:3]}];
	assign cur_bit  = id_byte[bit_cnt_q[2:0]];
	assign done     = (bit_cnt_q == ID_BITS);
	assign isol_ctx = (idx_q == IDX_ISOLATE) && (state_q == ST_ISOLATE) && !done;
	assign res_ctx  = (idx_q == IDX_RES_DATA) && (state_q == ST_CONFIG);
	assign res_len  = mem_q[LEN_ADDR][5:0];
	assign lose     = rd_end && isol_ctx && phase_q && !drove_q && saw_first_q
		&& (sense_q == SENSE_SECOND);

	key_detect #(
		.SEED (KEY_SEED),
		.LEN  (KEY_LEN)
	) u_key (
		.sys_clk_i (sys_clk_i),
		.reset_n_i (reset_n_i),
		.enable_i  (state_q == ST_WAIT_KEY),
		.wr_i      (addr_wr),
		.data_i    (io_wdata_i),
		.found_o   (key_found)
	);

	// read response
	always_comb begin
		resp_oe   = 1'b0;
		resp_data = 8'h00;
		case (idx_q)
			IDX_ISOLATE: begin
				if (isol_ctx && cur_bit) begin
					resp_oe   = 1'b1;
					resp_data = phase_q ? ISOL_SECOND : ISOL_FIRST;
				end
			end
			IDX_RES_DATA: begin
				resp_oe   = res_ctx;
				resp_data = mem_q[res_ptr_q];
			end
			IDX_STATUS: begin
				resp_oe   = (state_q == ST_CONFIG);
				resp_data = STATUS_READY;
			end
			IDX_CSN: begin
				resp_oe   = (state_q == ST_CONFIG);
				resp_data = csn_q;
			end
			default: begin
				resp_oe   = 1'b0;
				resp_data = 8'h00;
			end
		endcase
	end

	// data bus drivers
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			sd_oe_o  <= 1'b0;
			sd_o     <= 8'h00;
			rd_hit_q <= 1'b0;
			sense_q  <= 2'h0;
		end else begin
			rd_hit_q <= rd_hit;
			sd_oe_o  <= rd_hit && resp_oe;
			sd_o     <= (rd_hit && resp_oe) ? resp_data : 8'h00;
			if (rd_hit) begin
				sense_q <= sd_i[1:0];
			end
		end
	end

	// card state machine
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			state_q <= ST_WAIT_KEY;
		end else if (state_q == ST_WAIT_KEY) begin
			if (key_found) begin
				state_q <= ST_SLEEP;
			end
		end else if (data_wr && idx_q == IDX_CFG_CTRL && io_wdata_i[CTRL_WAIT_KEY_BIT]) begin
			state_q <= ST_WAIT_KEY;
		end else if (data_wr && idx_q == IDX_WAKE) begin
			case (state_q)
				ST_SLEEP: begin
					if (io_wdata_i == csn_q) begin
						state_q <= (csn_q == CSN_RESET) ? ST_ISOLATE : ST_CONFIG;
					end
				end
				default: begin
					if (io_wdata_i != csn_q) begin
						state_q <= ST_SLEEP;
					end
				end
			endcase
		end else if (data_wr && idx_q == IDX_CSN && state_q == ST_ISOLATE) begin
			state_q <= ST_CONFIG;
		end else if (lose) begin
			state_q <= ST_SLEEP;
		end
	end

	// card select number
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			csn_q <= CSN_RESET;
		end else if (data_wr && idx_q == IDX_CSN && state_q == ST_ISOLATE) begin
			csn_q <= io_wdata_i;
		end else if (data_wr && idx_q == IDX_CFG_CTRL && io_wdata_i[CTRL_RST_CSN_BIT]) begin
			csn_q <= CSN_RESET;
		end else if (data_wr && idx_q == IDX_VENDOR_RST_CSN) begin
			csn_q <= CSN_RESET;
		end
	end

	// index and read port address
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			idx_q     <= 8'h00;
			rd_port_q <= RD_PORT_RESET;
		end else begin
			if (addr_wr && state_q != ST_WAIT_KEY) begin
				idx_q <= io_wdata_i;
			end
			if (data_wr && idx_q == IDX_SET_RD && state_q == ST_ISOLATE) begin
				rd_port_q <= io_wdata_i;
			end
		end
	end

	// isolation shifter
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			bit_cnt_q   <= 7'h00;
			phase_q     <= 1'b0;
			drove_q     <= 1'b0;
			saw_first_q <= 1'b0;
		end else if (data_wr && idx_q == IDX_WAKE && state_q == ST_SLEEP) begin
			bit_cnt_q   <= 7'h00;
			phase_q     <= 1'b0;
			drove_q     <= 1'b0;
			saw_first_q <= 1'b0;
		end else if (rd_end && isol_ctx) begin
			if (!phase_q) begin
				phase_q     <= 1'b1;
				drove_q     <= cur_bit;
				saw_first_q <= (sense_q == SENSE_FIRST);
			end else begin
				phase_q <= 1'b0;
				if (!lose) begin
					bit_cnt_q <= bit_cnt_q + 7'h01;
				end
			end
		end
	end

	// resource pointer
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			res_ptr_q <= RES_START;
		end else if (data_wr && idx_q == IDX_WAKE && state_q == ST_SLEEP) begin
			res_ptr_q <= RES_START;
		end else if (rd_end && res_ctx) begin
			res_ptr_q <= (res_ptr_q == res_len) ? RES_START : res_ptr_q + 6'h01;
		end
	end

	// microcontroller load path
	sync_fifo #(
		.WIDTH (8),
		.DEPTH (LOAD_DEPTH)
	) u_load_fifo (
		.sys_clk_i   (sys_clk_i),
		.reset_n_i   (reset_n_i),
		.in_valid_i  (mcu_valid_i),
		.in_ready_o  (mcu_ready_o),
		.in_data_i   (mcu_data_i),
		.out_valid_o (drain_valid),
		.out_ready_i (drain_ready),
		.out_data_o  (drain_data)
	);

	assign drain_ready = !(rd_hit || rd_hit_q) && !mcu_start_i;

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i || mcu_start_i) begin
			load_ptr_q <= LEN_ADDR;
		end else if (drain_valid && drain_ready) begin
			load_ptr_q <= load_ptr_q + 6'h01;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (drain_valid && drain_ready) begin
			mem_q[load_ptr_q] <= drain_data;
		end
	end

	// checks
	chk_first_drive: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		rd_hit && isol_ctx && !phase_q && cur_bit |=> sd_oe_o && sd_o == ISOL_FIRST)
		else $error("first read of a one bit not driven as 55h");
	chk_zero_float: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		rd_hit && (idx_q == IDX_ISOLATE) && !cur_bit |=> !sd_oe_o)
		else $error("card drove bus for a zero bit");
	chk_second_drive: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		rd_hit && isol_ctx && phase_q && drove_q |=> sd_oe_o && sd_o == ISOL_SECOND)
		else $error("second read after drive not aah");
	chk_loser_sleeps: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		rd_end && isol_ctx && phase_q && !drove_q && saw_first_q
		&& sense_q == SENSE_SECOND |=> state_q == ST_SLEEP)
		else $error("losing card did not leave isolation");
	chk_bit_advance: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		rd_end && isol_ctx && phase_q && !lose
		|=> bit_cnt_q == $past(bit_cnt_q) + 7'h01)
		else $error("identifier did not advance after pair");
	chk_csn_assign: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		data_wr && idx_q == IDX_CSN && state_q == ST_ISOLATE
		|=> state_q == ST_CONFIG && csn_q == $past(io_wdata_i))
		else $error("csn write did not configure card");
	chk_bus_reset: assert property (@(posedge sys_clk_i)
		!reset_n_i |=> state_q == ST_WAIT_KEY && csn_q == CSN_RESET)
		else $error("bus reset did not return to key wait");
	chk_vendor_csn: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		data_wr && idx_q == IDX_VENDOR_RST_CSN |=> csn_q == CSN_RESET)
		else $error("vendor csn reset ignored");
	chk_res_wrap: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		rd_end && res_ctx && res_ptr_q == res_len |=> res_ptr_q == RES_START)
		else $error("resource pointer did not wrap");
	chk_quiet_unnumbered: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		rd_hit && state_q == ST_SLEEP |=> !sd_oe_o)
		else $error("sleeping card answered a read");
	chk_key_hold: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		state_q == ST_WAIT_KEY && !key_found |=> state_q == ST_WAIT_KEY)
		else $error("left key wait without key");

	cov_pass_done: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		state_q == ST_ISOLATE && done);
	cov_lose: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) lose);
	cov_config: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		state_q == ST_ISOLATE ##1 state_q == ST_CONFIG);
	cov_wrap: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
		rd_end && res_ctx && res_ptr_q == res_len);

endmodule

// ### isa_host.sv
/*
 isa host model running card isolation software, plus one rival card on
 the data bus. assumes design drives sd at negedge-stable registered timing.
*/
`timescale 1ns/10ps
module isa_host (
	// clock
	input  wire logic        sys_clk_i,
	// isa cycle
	output logic [15:0]      io_addr_o,
	output logic             io_wr_o,
	output logic [7:0]       io_wdata_o,
	output logic             io_rd_o,
	// data bus
	input  wire logic [7:0]  card_d_i,
	input  wire logic        card_oe_i,
	output logic [7:0]       bus_o,
	// rival card
	input  wire logic        rival_en_i,
	input  wire logic [71:0] rival_id_i
);
	logic [15:0] rd_port;
	logic [6:0]  bit_n;
	logic        phase;
	logic        rv_oe;
	logic [7:0]  last_q;

	initial begin
		io_addr_o  = 16'h0000;
		io_wr_o    = 1'b0;
		io_wdata_o = 8'h00;
		io_rd_o    = 1'b0;
		rd_port    = 16'h0203;
		bit_n      = 7'h00;
		phase      = 1'b0;
		last_q     = 8'h00;
	end

	// rival answers its own id bit
	assign rv_oe = rival_en_i && io_rd_o && io_addr_o == rd_port && rival_id_i[bit_n];
	// floating bus shows the inverse of the last driven value
	assign bus_o = card_oe_i ? card_d_i : rv_oe ? (phase ? 8'haa : 8'h55) : ~last_q;

	always @(posedge sys_clk_i) begin
		if (card_oe_i || rv_oe) begin
			last_q <= bus_o;
		end
	end

	task automatic io_write(input logic [15:0] a, input logic [7:0] d);
		@(negedge sys_clk_i);
		io_addr_o  = a;
		io_wdata_o = d;
		io_wr_o    = 1'b1;
		@(negedge sys_clk_i);
		io_wr_o    = 1'b0;
	endtask

	task automatic cmd(input logic [7:0] idx, input logic [7:0] d);
		io_write(16'h0279, idx);
		io_write(16'h0a79, d);
	endtask

	task automatic set_port(input logic [7:0] d);
		cmd(8'h00, d);
		rd_port = {6'h00, d, 2'b11};
	endtask

	task automatic io_read(input int n, output logic [7:0] d);
		@(negedge sys_clk_i);
		io_addr_o = rd_port;
		io_rd_o   = 1'b1;
		repeat (n) @(negedge sys_clk_i);
		d       = bus_o;
		io_rd_o = 1'b0;
		@(negedge sys_clk_i);
	endtask

	task automatic send_key(input int n);
		logic [7:0] k;
		k = 8'h6a;
		for (int i = 0; i < n; i++) begin
			io_write(16'h0279, k);
			k = {k[0] ^ k[1], k[7:1]};
		end
	endtask

	function automatic logic [7:0] cksum(input logic [63:0] v);
		logic [7:0] c;
		c = 8'h6a;
		for (int i = 0; i < 64; i++) c = {c[0] ^ c[1] ^ v[i], c[7:1]};
		return c;
	endfunction

	task automatic iso_pass(output logic [71:0] id, output logic ok);
		logic [7:0] d1;
		logic [7:0] d2;
		io_write(16'h0279, 8'h01);
		repeat (20) @(negedge sys_clk_i);
		for (int i = 0; i < 72; i++) begin
			bit_n = 7'(i);
			phase = 1'b0;
			io_read(3, d1);
			phase = 1'b1;
			io_read(3, d2);
			id[i] = (d1 == 8'h55) && (d2 == 8'haa);
			repeat (20) @(negedge sys_clk_i);
		end
		phase = 1'b0;
		ok    = cksum(id[63:0]) == id[71:64];
	endtask
endmodule

// ### tb.sv
/*
 self-checking bench for card isolation: load, key, isolation passes,
 command table, fifo fill. assumes isa_host partner model.
*/
`timescale 1ns/10ps
module tb;
	import pnp_pkg::*;
	typedef struct packed {
		logic [7:0]  idx;
		logic [7:0]  dat;
		card_state_t st;
		logic [7:0]  csn;
	} row_t;
	logic        sys_clk_i;
	logic        reset_n_i;
	logic [15:0] io_addr;
	logic        io_wr;
	logic [7:0]  io_wdata;
	logic        io_rd;
	logic [7:0]  sd_bus;
	logic [7:0]  sd_o;
	logic        sd_oe_o;
	logic        mcu_start;
	logic        mcu_valid;
	logic [7:0]  mcu_data;
	logic        mcu_ready_o;
	card_state_t card_state_o;
	logic [7:0]  csn_o;
	logic        rival_en;
	logic [71:0] rival_id;
	logic [7:0]  img [13];
	logic [63:0] id64;
	logic [71:0] got;
	logic        ok;
	logic [7:0]  d;
	int          ptr;
	int          error_cnt;
	int          cmp_count;
	int          cycles;
	row_t        rows [13];

	pnp_card_isolation u_pnp_card_isolation (
		.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .io_addr_i(io_addr), .io_wr_i(io_wr),
		.io_wdata_i(io_wdata), .io_rd_i(io_rd), .sd_i(sd_bus), .sd_o(sd_o), .sd_oe_o(sd_oe_o),
		.mcu_start_i(mcu_start), .mcu_valid_i(mcu_valid), .mcu_data_i(mcu_data),
		.mcu_ready_o(mcu_ready_o), .card_state_o(card_state_o), .csn_o(csn_o));

	isa_host u_isa_host (
		.sys_clk_i(sys_clk_i), .io_addr_o(io_addr), .io_wr_o(io_wr), .io_wdata_o(io_wdata),
		.io_rd_o(io_rd), .card_d_i(sd_o), .card_oe_i(sd_oe_o), .bus_o(sd_bus),
		.rival_en_i(rival_en), .rival_id_i(rival_id));

	initial begin
		sys_clk_i = 1'b0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end

	task automatic check(input string name, input logic [71:0] seen, input logic [71:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 60000) begin
			error_cnt++;
			finish_test();
		end
	end

	task automatic mcu_push(input logic [7:0] v);
		@(negedge sys_clk_i);
		mcu_valid = 1'b1;
		mcu_data  = v;
		while (mcu_ready_o !== 1'b1) @(negedge sys_clk_i);
		@(negedge sys_clk_i);
		mcu_valid = 1'b0;
	endtask

	task automatic pulse_start;
		@(negedge sys_clk_i);
		mcu_start = 1'b1;
		@(negedge sys_clk_i);
		mcu_start = 1'b0;
	endtask

	initial begin
		reset_n_i = 1'b0;
		mcu_start = 1'b0;
		mcu_valid = 1'b0;
		mcu_data  = 8'h00;
		rival_en  = 1'b0;
		rival_id  = '0;
		error_cnt = 0;
		cmp_count = 0;
		cycles    = 0;
		img  = '{8'h0c, 8'h24, 8'h36, 8'h12, 8'ha5, 8'h01, 8'h00, 8'h00, 8'h10, 8'h00,
			8'h71, 8'h92, 8'hc3};
		id64 = {img[8], img[7], img[6], img[5], img[4], img[3], img[2], img[1]};
		img[9] = u_isa_host.cksum(id64);
		rows = '{'{8'h03, 8'h02, ST_SLEEP, 8'h01}, '{8'h03, 8'h01, ST_CONFIG, 8'h01},
			'{8'h06, 8'h05, ST_CONFIG, 8'h01}, '{8'h02, 8'h04, ST_CONFIG, 8'h00},
			'{8'h03, 8'h07, ST_SLEEP, 8'h00}, '{8'h03, 8'h00, ST_ISOLATE, 8'h00},
			'{8'h06, 8'h03, ST_CONFIG, 8'h03}, '{8'hf4, 8'h5a, ST_CONFIG, 8'h00},
			'{8'h03, 8'h00, ST_CONFIG, 8'h00}, '{8'h03, 8'h04, ST_SLEEP, 8'h00},
			'{8'h03, 8'h00, ST_ISOLATE, 8'h00}, '{8'h06, 8'h09, ST_CONFIG, 8'h09},
			'{8'h02, 8'h02, ST_WAIT_KEY, 8'h09}};
		repeat (12) @(negedge sys_clk_i);
		reset_n_i = 1'b1;
		check("state", card_state_o, ST_WAIT_KEY);
		check("csn", csn_o, 8'h00);
		check("drive", sd_oe_o, 1'b0);
		check("ready", mcu_ready_o, 1'b1);
		pulse_start();
		for (int i = 0; i < 13; i++) mcu_push(img[i]);
		// key sequence, cut short and restarted
		u_isa_host.cmd(IDX_WAKE, 8'h00);
		u_isa_host.send_key(31);
		check("short key", card_state_o, ST_WAIT_KEY);
		u_isa_host.io_write(ADDR_PORT, 8'h00);
		u_isa_host.send_key(32);
		repeat (2) @(negedge sys_clk_i);
		check("keyed", card_state_o, ST_SLEEP);
		u_isa_host.cmd(IDX_CSN, 8'h05);
		check("csn before iso", csn_o, 8'h00);
		u_isa_host.cmd(IDX_WAKE, 8'h00);
		check("wake", card_state_o, ST_ISOLATE);
		u_isa_host.set_port(8'h81);
		// pass with a rival winning on bit zero
		rival_en = 1'b1;
		rival_id = {~u_isa_host.cksum(id64 | 64'h1), id64 | 64'h1};
		u_isa_host.iso_pass(got, ok);
		rival_en = 1'b0;
		check("rival id", got, rival_id);
		check("conflict", ok, 1'b0);
		check("loser", card_state_o, ST_SLEEP);
		u_isa_host.cmd(IDX_WAKE, 8'h00);
		if (!ok) begin
			u_isa_host.set_port(8'h82);
		end
		u_isa_host.iso_pass(got, ok);
		check("serial id", got, {img[9], id64});
		check("checksum", ok, 1'b1);
		check("winner", card_state_o, ST_ISOLATE);
		u_isa_host.cmd(IDX_CSN, 8'h01);
		check("csn set", csn_o, 8'h01);
		check("config", card_state_o, ST_CONFIG);
		// numbered card sits out a later pass
		u_isa_host.cmd(IDX_WAKE, 8'h00);
		u_isa_host.iso_pass(got, ok);
		check("numbered quiet", got, 72'h0);
		check("no card left", ok, 1'b0);
		u_isa_host.cmd(IDX_WAKE, 8'h01);
		check("reselect", card_state_o, ST_CONFIG);
		u_isa_host.io_write(ADDR_PORT, IDX_STATUS);
		u_isa_host.io_read(3, d);
		check("status", d, STATUS_READY);
		u_isa_host.io_write(ADDR_PORT, IDX_RES_DATA);
		ptr = 1;
		for (int i = 0; i < 14; i++) begin
			u_isa_host.io_read(3, d);
			check("resource", d, img[ptr]);
			ptr = (ptr == 12) ? 1 : ptr + 1;
		end
		// fifo fill while a host read stalls the drain
		pulse_start();
		fork
			u_isa_host.io_read(30, d);
			begin
				repeat (3) @(negedge sys_clk_i);
				for (int i = 0; i < 8; i++) mcu_push(8'(i));
				@(negedge sys_clk_i);
				check("fifo full", mcu_ready_o, 1'b0);
			end
		join
		repeat (12) @(negedge sys_clk_i);
		check("fifo drained", mcu_ready_o, 1'b1);
		foreach (rows[i]) begin
			u_isa_host.cmd(rows[i].idx, rows[i].dat);
			check("row state", card_state_o, rows[i].st);
			check("row csn", csn_o, rows[i].csn);
		end
		u_isa_host.send_key(32);
		repeat (2) @(negedge sys_clk_i);
		check("rekeyed", card_state_o, ST_SLEEP);
		reset_n_i = 1'b0;
		repeat (2) @(negedge sys_clk_i);
		reset_n_i = 1'b1;
		check("reset state", card_state_o, ST_WAIT_KEY);
		check("reset csn", csn_o, 8'h00);
		finish_test();
	end
endmodule
